// ### core/asla_pkg.sv
// Package of constants and types for the add, subtract and logic datapath
package asla_pkg;

   // Data path and bus widths
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned CTRL_W = 18;

   // Register byte offsets on the APB window
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;  // Operation launch word
   localparam logic [ADDR_W-1:0] OFS_OPA    = 8'h04;  // First source value
   localparam logic [ADDR_W-1:0] OFS_OPB    = 8'h08;  // Second source value
   localparam logic [ADDR_W-1:0] OFS_IMM    = 8'h0C;  // Immediate value
   localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h10;  // Last result, read only
   localparam logic [ADDR_W-1:0] OFS_FLAGS  = 8'h14;  // Condition flags
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;  // Outcome of last launch

   // Status word field positions
   localparam int unsigned STATUS_DONE_BIT = 0;
   localparam int unsigned STATUS_ILL_BIT  = 1;
   localparam int unsigned STATUS_DEST_LSB = 4;

   // Register numbers with special meaning
   localparam logic [3:0] REG_SP = 4'hD;
   localparam logic [3:0] REG_PC = 4'hF;

   // Immediate limits
   localparam logic [DATA_W-1:0] IMM_LOW3_MAX = 32'h0000_0007;  // 0 to 7
   localparam logic [DATA_W-1:0] IMM_BYTE_MAX = 32'h0000_00FF;  // 0 to 255
   localparam logic [DATA_W-1:0] IMM_PCSP_MAX = 32'h0000_03FC;  // 0 to 1020
   localparam logic [DATA_W-1:0] IMM_SPSP_MAX = 32'h0000_01FC;  // 0 to 508

   // Reset values
   localparam logic [DATA_W-1:0] RST_WORD  = 32'h0000_0000;
   localparam logic [3:0]        RST_FLAGS = 4'h0;

   // Operation codes held in the low nibble of the launch word
   typedef enum logic [3:0] {
      OP_ADD_PLAIN             = 4'h0,
      OP_ADD_FLAG_SETTING      = 4'h1,
      OP_ADD_WITH_CARRY        = 4'h2,
      OP_SUBTRACT_PLAIN        = 4'h3,
      OP_SUBTRACT_FLAG_SETTING = 4'h4,
      OP_SUBTRACT_WITH_CARRY   = 4'h5,
      OP_REVERSE_SUBTRACT      = 4'h6,
      OP_LOGICAL_AND           = 4'h7,
      OP_INCLUSIVE_OR          = 4'h8,
      OP_EXCLUSIVE_OR          = 4'h9,
      OP_BIT_CLEAR             = 4'hA
   } asla_op_e;

   // Launch word layout, bit 0 upward: op, dest, first src, second src
   typedef struct packed {
      logic       rd_omit;  // Destination field omitted
      logic       use_imm;  // Second operand is the immediate
      logic [3:0] rm;       // Second source register number
      logic [3:0] rn;       // First source register number
      logic [3:0] rd;       // Destination register number
      logic [3:0] op;       // Operation code
   } asla_ctrl_s;

   // Condition flags, negative in bit 3 down to overflow in bit 0
   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } asla_flags_s;

   // Bus answer sequencer, Gray coded
   typedef enum logic [1:0] {
      BUS_IDLE   = 2'h0,
      BUS_ANSWER = 2'h1
   } asla_bus_e;

endpackage

// ### core/asla_alu.sv
// Add, subtract and logic datapath behind an APB register window
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
module asla_alu (
   input  wire logic                  CLK_SYS_I,
   input  wire logic                  SYS_RST_I,
   input  wire logic                  PSEL_I,
   input  wire logic                  PENABLE_I,
   input  wire logic                  PWRITE_I,
   input  wire logic [7:0]            PADDR_I,
   input  wire logic [31:0]           PWDATA_I,
   output logic      [31:0]           PRDATA_O,
   output logic                       PREADY_O,
   output logic                       PSLVERR_O,
   output logic      [31:0]           RESULT_O,
   output logic      [3:0]            DEST_O,
   output logic                       WR_EN_O,
   output asla_pkg::asla_flags_s      FLAGS_O
);
   import asla_pkg::*;

   // Bus answer state
   asla_bus_e            bus_q,      bus_d;      // Answer sequencer
   logic                 pready_q,   pready_d;   // Ready toward master
   logic                 pslverr_q,  pslverr_d;  // Unmapped address answer
   logic [DATA_W-1:0]    prdata_q,   prdata_d;   // Read data held for answer

   // Datapath state
   asla_ctrl_s           ctrl_q,     ctrl_d;     // Last launch word
   logic [DATA_W-1:0]    opa_q,      opa_d;      // First source value
   logic [DATA_W-1:0]    opb_q,      opb_d;      // Second source value
   logic [DATA_W-1:0]    imm_q,      imm_d;      // Immediate value
   logic [DATA_W-1:0]    res_q,      res_d;      // Result toward register file
   asla_flags_s          flags_q,    flags_d;    // Condition flags
   logic [3:0]           dest_q,     dest_d;     // Destination register number
   logic                 wren_q,     wren_d;     // One cycle write strobe
   logic                 done_q,     done_d;     // A launch has been seen
   logic                 ill_q,      ill_d;      // Last launch was illegal

   // Combinational execution signals
   logic                 commit;     // Access completes at this edge
   logic                 go;         // Launch word written at this edge
   asla_ctrl_s           wctrl;      // Launch word being written
   logic [3:0]           rd_eff;     // Destination after omission rule
   logic                 low_dn;     // Destination and first source are low
   logic                 low_all;    // All three fields are low
   logic                 imm_word;   // Immediate is a multiple of four
   logic                 legal;      // Register and immediate combination allowed
   logic                 is_arith;   // Adder drives carry and overflow
   logic                 sets_flags; // Operation updates flags
   logic [DATA_W-1:0]    opnd_b;     // Register or immediate second operand
   logic [DATA_W-1:0]    add_x;      // Adder first input
   logic [DATA_W-1:0]    add_y;      // Adder second input
   logic                 add_cin;    // Adder carry in
   logic [DATA_W:0]      sum;        // Adder output with carry out
   logic [DATA_W-1:0]    result;     // Selected result
   asla_flags_s          new_flags;  // Flags the operation would produce

   // An access completes only on the edge where ready is already high
   assign commit = (bus_q == BUS_ANSWER) && PSEL_I && PENABLE_I;
   assign go     = commit && PWRITE_I && (PADDR_I == OFS_CTRL);
   assign wctrl  = asla_ctrl_s'(PWDATA_I[CTRL_W-1:0]);

   // Legality of the written register and immediate combination
   always_comb begin
      rd_eff   = wctrl.rd_omit ? wctrl.rn : wctrl.rd;
      low_dn   = !rd_eff[3] && !wctrl.rn[3];
      low_all  = low_dn && !wctrl.rm[3];
      imm_word = (imm_q[1:0] == 2'h0);
      opnd_b   = wctrl.use_imm ? imm_q : opb_q;
      case (asla_op_e'(wctrl.op))
         // Carry forms: low registers, destination equals first source
         OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_CARRY: begin
            legal = low_all && (rd_eff == wctrl.rn) && !wctrl.use_imm;
         end
         // Plain add: immediate to SP or PC, SP to SP, or registers with destination equal to first source, not both sources PC
         OP_ADD_PLAIN: begin
            if (wctrl.use_imm) begin
               legal = imm_word &&
                       ((!rd_eff[3] && (wctrl.rn == REG_SP || wctrl.rn == REG_PC) &&
                         imm_q <= IMM_PCSP_MAX) ||
                        (rd_eff == REG_SP && wctrl.rn == REG_SP &&
                         imm_q <= IMM_SPSP_MAX));
            end else begin
               legal = (rd_eff == wctrl.rn) &&
                       !(wctrl.rn == REG_PC && wctrl.rm == REG_PC);
            end
         end
         // Plain subtract exists only as SP minus immediate
         OP_SUBTRACT_PLAIN: begin
            legal = wctrl.use_imm && imm_word && rd_eff == REG_SP &&
                    wctrl.rn == REG_SP && imm_q <= IMM_SPSP_MAX;
         end
         // Flag setting add and subtract: small or byte immediate, or registers
         OP_ADD_FLAG_SETTING, OP_SUBTRACT_FLAG_SETTING: begin
            if (wctrl.use_imm) begin
               legal = low_dn && (imm_q <= IMM_LOW3_MAX ||
                                  (imm_q <= IMM_BYTE_MAX && rd_eff == wctrl.rn));
            end else begin
               legal = low_all;
            end
         end
         // Negation only accepts a zero immediate
         OP_REVERSE_SUBTRACT: begin
            legal = low_dn && (!wctrl.use_imm || imm_q == RST_WORD);
         end
         // Logic forms: low registers, destination equals first source
         OP_LOGICAL_AND, OP_INCLUSIVE_OR, OP_EXCLUSIVE_OR, OP_BIT_CLEAR: begin
            legal = low_all && (rd_eff == wctrl.rn) && !wctrl.use_imm;
         end
         // Unused codes are refused
         default: begin
            legal = 1'b0;
         end
      endcase
   end

   // Adder input selection; one shared adder serves every arithmetic form
   always_comb begin
      add_x      = opa_q;
      add_y      = opnd_b;
      add_cin    = 1'b0;
      is_arith   = 1'b1;
      sets_flags = 1'b1;
      case (asla_op_e'(wctrl.op))
         OP_ADD_PLAIN: begin
            sets_flags = 1'b0;
         end
         OP_ADD_FLAG_SETTING: begin
            add_cin = 1'b0;
         end
         OP_ADD_WITH_CARRY: begin
            add_cin = flags_q.c;
         end
         OP_SUBTRACT_PLAIN: begin
            add_y      = ~opnd_b;
            add_cin    = 1'b1;
            sets_flags = 1'b0;
         end
         OP_SUBTRACT_FLAG_SETTING: begin
            add_y   = ~opnd_b;
            add_cin = 1'b1;
         end
         // One more is deducted when carry is set, so carry in is its inverse
         OP_SUBTRACT_WITH_CARRY: begin
            add_y   = ~opnd_b;
            add_cin = ~flags_q.c;
         end
         // Zero minus first source: inverted source plus one
         OP_REVERSE_SUBTRACT: begin
            add_x   = RST_WORD;
            add_y   = ~opa_q;
            add_cin = 1'b1;
         end
         default: begin
            is_arith = 1'b0;
         end
      endcase
   end

   // Result and flag production
   always_comb begin
      sum = {1'b0, add_x} + {1'b0, add_y} + {{DATA_W{1'b0}}, add_cin};
      case (asla_op_e'(wctrl.op))
         OP_LOGICAL_AND:  result = opa_q & opb_q;
         OP_INCLUSIVE_OR: result = opa_q | opb_q;
         OP_EXCLUSIVE_OR: result = opa_q ^ opb_q;
         OP_BIT_CLEAR:    result = opa_q & ~opb_q;
         default:         result = sum[DATA_W-1:0];
      endcase
      new_flags   = flags_q;
      new_flags.n = result[DATA_W-1];
      new_flags.z = (result == RST_WORD);
      // Logic forms leave carry and overflow alone
      if (is_arith) begin
         new_flags.c = sum[DATA_W];
         new_flags.v = (add_x[DATA_W-1] == add_y[DATA_W-1]) &&
                       (result[DATA_W-1] != add_x[DATA_W-1]);
      end else begin
         new_flags.c = flags_q.c;
         new_flags.v = flags_q.v;
      end
   end

   // Bus answer: one wait state, so read data and error come from flops
   always_comb begin
      bus_d     = bus_q;
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      prdata_d  = prdata_q;
      case (bus_q)
         BUS_IDLE: begin
            // Access phase seen: prepare the answer for the next edge
            if (PSEL_I && PENABLE_I) begin
               bus_d    = BUS_ANSWER;
               pready_d = 1'b1;
               prdata_d = RST_WORD;
               case (PADDR_I)
                  OFS_CTRL:   prdata_d = DATA_W'(ctrl_q);
                  OFS_OPA:    prdata_d = opa_q;
                  OFS_OPB:    prdata_d = opb_q;
                  OFS_IMM:    prdata_d = imm_q;
                  OFS_RESULT: prdata_d = res_q;
                  OFS_FLAGS:  prdata_d = DATA_W'(flags_q);
                  OFS_STATUS: prdata_d = DATA_W'({dest_q, 2'h0, ill_q, done_q});
                  default:    pslverr_d = 1'b1;
               endcase
               if (PWRITE_I) begin
                  prdata_d = RST_WORD;
               end
            end
         end
         BUS_ANSWER: begin
            bus_d = BUS_IDLE;
         end
         default: begin
            bus_d = BUS_IDLE;
         end
      endcase
   end

   // Register writes and launch commit; all take effect on the ready edge
   always_comb begin
      ctrl_d  = ctrl_q;
      opa_d   = opa_q;
      opb_d   = opb_q;
      imm_d   = imm_q;
      res_d   = res_q;
      flags_d = flags_q;
      dest_d  = dest_q;
      done_d  = done_q;
      ill_d   = ill_q;
      wren_d  = 1'b0;
      if (commit && PWRITE_I) begin
         case (PADDR_I)
            OFS_OPA:   opa_d   = PWDATA_I;
            OFS_OPB:   opb_d   = PWDATA_I;
            OFS_IMM:   imm_d   = PWDATA_I;
            OFS_FLAGS: flags_d = asla_flags_s'(PWDATA_I[3:0]);
            default: begin
            end
         endcase
      end
      // An illegal launch writes nothing and leaves flags as they were
      if (go) begin
         ctrl_d = wctrl;
         done_d = 1'b1;
         ill_d  = !legal;
         dest_d = rd_eff;
         if (legal) begin
            res_d  = result;
            wren_d = 1'b1;
            if (sets_flags) begin
               flags_d = new_flags;
            end
         end
      end
   end

   // State registers
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         bus_q     <= BUS_IDLE;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= RST_WORD;
         ctrl_q    <= asla_ctrl_s'(RST_WORD[CTRL_W-1:0]);
         opa_q     <= RST_WORD;
         opb_q     <= RST_WORD;
         imm_q     <= RST_WORD;
         res_q     <= RST_WORD;
         flags_q   <= asla_flags_s'(RST_FLAGS);
         dest_q    <= 4'h0;
         wren_q    <= 1'b0;
         done_q    <= 1'b0;
         ill_q     <= 1'b0;
      end else begin
         bus_q     <= bus_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
         ctrl_q    <= ctrl_d;
         opa_q     <= opa_d;
         opb_q     <= opb_d;
         imm_q     <= imm_d;
         res_q     <= res_d;
         flags_q   <= flags_d;
         dest_q    <= dest_d;
         wren_q    <= wren_d;
         done_q    <= done_d;
         ill_q     <= ill_d;
      end
   end

   // Outputs straight from flops
   assign PRDATA_O  = prdata_q;
   assign PREADY_O  = pready_q;
   assign PSLVERR_O = pslverr_q;  // Only ever set together with ready
   assign RESULT_O  = res_q;
   assign DEST_O    = dest_q;
   assign WR_EN_O   = wren_q;
   assign FLAGS_O   = flags_q;

   // Checks on results and flags one edge after a launch, and on the bus wait state
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SYS_RST_I);

   a_adc_sum:
      assert property (go && legal && wctrl.op == OP_ADD_WITH_CARRY |=>
         WR_EN_O && RESULT_O == $past(opa_q + opb_q + {31'h0, flags_q.c}))
      else $error("add with carry result wrong");
   a_add_keeps:
      assert property (go && legal && wctrl.op == OP_ADD_PLAIN |=>
         FLAGS_O == $past(flags_q) && RESULT_O == $past(opa_q + opnd_b))
      else $error("plain add result or flags wrong");
   a_rsb_neg:
      assert property (go && legal && wctrl.op == OP_REVERSE_SUBTRACT |=>
         RESULT_O == $past(RST_WORD - opa_q) && FLAGS_O.c == (RESULT_O == RST_WORD))
      else $error("reverse subtract wrong");
   a_sbc_diff:
      assert property (go && legal && wctrl.op == OP_SUBTRACT_WITH_CARRY |=>
         RESULT_O == $past(opa_q - opb_q - {31'h0, flags_q.c}))
      else $error("subtract with carry result wrong");
   a_sub_flags:
      assert property (go && legal && wctrl.op == OP_SUBTRACT_FLAG_SETTING |=>
         RESULT_O == $past(opa_q - opnd_b) && FLAGS_O.c == $past(opa_q >= opnd_b))
      else $error("flag setting subtract wrong");
   a_omit_dest:
      assert property (go && wctrl.rd_omit |=> DEST_O == $past(wctrl.rn))
      else $error("omitted destination not first source");
   a_carry_low:
      assert property (go && wctrl.op == OP_ADD_WITH_CARRY && wctrl.rd[3] && !wctrl.rd_omit
         |=> !WR_EN_O && FLAGS_O == $past(flags_q))
      else $error("high register accepted by carry form");
   a_pc_pair:
      assert property (go && wctrl.op == OP_ADD_PLAIN && !wctrl.use_imm &&
         wctrl.rn == REG_PC && wctrl.rm == REG_PC |=> !WR_EN_O ##1 !WR_EN_O)
      else $error("both sources PC accepted");
   a_logic_cv:
      assert property (go && legal && wctrl.op >= OP_LOGICAL_AND |=>
         FLAGS_O.c == $past(flags_q.c) && FLAGS_O.v == $past(flags_q.v) &&
         FLAGS_O.n == RESULT_O[31])
      else $error("logic op disturbed carry or overflow");
   a_bic_value:
      assert property (go && legal && wctrl.op == OP_BIT_CLEAR |=>
         RESULT_O == $past(opa_q & ~opb_q))
      else $error("bit clear result wrong");
   a_zero_flag:
      assert property (WR_EN_O && $past(sets_flags) |->
         FLAGS_O.z == (RESULT_O == RST_WORD))
      else $error("zero flag disagrees with result");
   a_answer_wait:
      assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
      else $error("bus answer not after one wait state");

endmodule // asla_alu

// ### tb/test_add_sub_logic_alu.sv
// Self-checking bench for the add, subtract and logic datapath
`timescale 1ns/1ps
module test_add_sub_logic_alu;
   import asla_pkg::*;

   localparam int LIMIT = 5000;  // Cycle ceiling, far above the expected run

   logic        clk_sys;          // 40 MHz system clock
   logic        sys_rst;          // Synchronous reset, active high
   logic        psel;             // APB select
   logic        penable;          // APB enable
   logic        pwrite;           // APB direction
   logic [7:0]  paddr;            // APB byte address
   logic [31:0] pwdata;           // APB write data
   logic [31:0] prdata;           // APB read data
   logic        pready;           // APB ready
   logic        pslverr;          // APB error
   logic [31:0] result;           // Datapath result
   logic [3:0]  dest;             // Destination register number
   logic        wr_en;            // Result write strobe
   asla_flags_s flags;            // Condition flags
   int          num_errors = 0;   // Mismatches seen
   int          comparisons = 0;  // Comparisons made
   int          cycles = 0;       // Hang guard count

   // Clock: invert every half period
   initial clk_sys = 1'b0;
   always #12.5 clk_sys = ~clk_sys;

   asla_alu u_asla_alu (
      .CLK_SYS_I (clk_sys),
      .SYS_RST_I (sys_rst),
      .PSEL_I    (psel),
      .PENABLE_I (penable),
      .PWRITE_I  (pwrite),
      .PADDR_I   (paddr),
      .PWDATA_I  (pwdata),
      .PRDATA_O  (prdata),
      .PREADY_O  (pready),
      .PSLVERR_O (pslverr),
      .RESULT_O  (result),
      .DEST_O    (dest),
      .WR_EN_O   (wr_en),
      .FLAGS_O   (flags)
   );

   // Verdict and end of run, reached from the main sequence or the hang guard
   task automatic conclude();
      if (num_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Compare a word
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Compare a nibble (flags, register numbers, single strobes)
   task automatic chk_nib(input string what, input logic [3:0] exp, input logic [3:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= adr;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      // No fixed wait: the loop ends when pready is seen high, or else at the hang guard
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reference arithmetic: {N,Z,C,V, result}; subtract is add of the inverse plus one, or plus the inverted carry for the carry form
   function automatic logic [35:0] model(input logic [3:0] op, input logic [31:0] a,
                                         input logic [31:0] b, input logic [3:0] f);
      logic [32:0] s;
      logic [31:0] x;
      logic [31:0] y;
      logic [31:0] r;
      logic [3:0]  fo;
      logic        sb;
      logic        ci;
      sb = op inside {OP_SUBTRACT_PLAIN, OP_SUBTRACT_FLAG_SETTING, OP_SUBTRACT_WITH_CARRY};
      x = (op == OP_REVERSE_SUBTRACT) ? 32'h0 : a;
      y = (op == OP_REVERSE_SUBTRACT) ? ~a : (sb ? ~b : b);
      ci = (op == OP_ADD_WITH_CARRY) ? f[1] : (op == OP_SUBTRACT_WITH_CARRY) ? ~f[1] :
           (sb || op == OP_REVERSE_SUBTRACT);
      s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
      r = s[31:0];
      fo = {r[31], r == 32'h0, s[32], (x[31] == y[31]) && (r[31] != x[31])};
      case (op)
         OP_ADD_PLAIN, OP_SUBTRACT_PLAIN: fo = f;
         OP_LOGICAL_AND: r = a & b;
         OP_INCLUSIVE_OR: r = a | b;
         OP_EXCLUSIVE_OR: r = a ^ b;
         OP_BIT_CLEAR: r = a & ~b;
         default: ;
      endcase
      // Logic forms touch only negative and zero
      if (op >= OP_LOGICAL_AND) fo = {r[31], r == 32'h0, f[1:0]};
      return {fo, r};
   endfunction

   // Load operands and flags, launch, then check outputs and registers
   task automatic run(input logic [3:0] op, input logic [11:0] regs, input logic [1:0] mode,
                      input logic [31:0] a, input logic [31:0] b, input logic [31:0] imm,
                      input logic [3:0] fin, input logic legal);
      logic [35:0] e;
      logic [31:0] d;
      logic        err;
      apb(1'b1, OFS_OPA, a, d, err);
      apb(1'b1, OFS_OPB, b, d, err);
      apb(1'b1, OFS_IMM, imm, d, err);
      apb(1'b1, OFS_FLAGS, {28'h000_0000, fin}, d, err);
      // A refused launch must leave result and flags as they stand
      e = legal ? model(op, a, mode[0] ? imm : b, fin) : {fin, result};
      apb(1'b1, OFS_CTRL, {14'h0000, mode, regs, op}, d, err);
      #1;
      chk_nib("write strobe", {3'b000, legal}, {3'b000, wr_en});
      chk_word("result", e[31:0], result);
      chk_nib("flags", e[35:32], flags);
      if (legal) chk_nib("destination", mode[1] ? regs[7:4] : regs[3:0], dest);
      apb(1'b0, OFS_STATUS, 32'h0, d, err);
      chk_nib("status", {2'b00, ~legal, 1'b1}, {2'b00, d[1:0]});
      chk_nib("status destination", mode[1] ? regs[7:4] : regs[3:0], d[7:4]);
      apb(1'b0, OFS_RESULT, 32'h0, d, err);
      chk_word("result register", e[31:0], d);
      // Launch word and flags read back through the bus
      apb(1'b0, OFS_CTRL, 32'h0, d, err);
      chk_word("launch word", {14'h0000, mode, regs, op}, d);
      apb(1'b0, OFS_FLAGS, 32'h0, d, err);
      chk_nib("flags register", e[35:32], d[3:0]);
   endtask

   // Main sequence
   initial begin
      logic [31:0] d;
      logic        err;
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk_word("result after reset", RST_WORD, result);
      chk_nib("flags after reset", RST_FLAGS, flags);
      // Every mapped register reads its reset value without error
      for (int k = 0; k <= 24; k += 4) begin
         apb(1'b0, 8'(k), 32'h0, d, err);
         chk_word("reset value", RST_WORD, d);
         chk_nib("bus error", 4'h0, {3'b000, err});
      end
      // Read-only place ignores a write, unmapped places answer with an error
      apb(1'b1, OFS_RESULT, 32'h1234_5678, d, err);
      chk_nib("read-only write error", 4'h0, {3'b000, err});
      apb(1'b0, OFS_RESULT, 32'h0, d, err);
      chk_word("read-only register", RST_WORD, d);
      apb(1'b0, 8'h1C, 32'h0, d, err);
      chk_word("unmapped read data", 32'h0, d);
      chk_nib("unmapped read error", 4'h1, {3'b000, err});
      apb(1'b1, 8'h40, 32'hDEAD_BEEF, d, err);
      chk_nib("unmapped write error", 4'h1, {3'b000, err});
      // Columns: op, {rm,rn,rd}, {omit,imm}, first, second, immediate, flags in, legal
      run(4'h1, 12'h321, 2'b00, 32'h7FFF_FFFF, 32'h1, 32'h0, 4'h0, 1'b1);
      run(4'h0, 12'hA99, 2'b00, 32'hFFFF_FFFF, 32'h1, 32'h0, 4'hF, 1'b1);
      run(4'h0, 12'hFFF, 2'b00, 32'h4, 32'h8, 32'h0, 4'h0, 1'b0);
      run(4'h2, 12'h322, 2'b00, 32'hFFFF_FFFF, 32'h0, 32'h0, 4'h2, 1'b1);
      run(4'h2, 12'h322, 2'b00, 32'h1, 32'h2, 32'h0, 4'h0, 1'b1);
      run(4'h2, 12'h342, 2'b00, 32'h1, 32'h2, 32'h0, 4'h0, 1'b0);
      run(4'h2, 12'h822, 2'b00, 32'h1, 32'h2, 32'h0, 4'h0, 1'b0);
      run(4'h2, 12'h399, 2'b00, 32'h1, 32'h2, 32'h0, 4'h2, 1'b0);
      run(4'h4, 12'h044, 2'b01, 32'h10, 32'h0, 32'hFF, 4'h0, 1'b1);
      run(4'h4, 12'h021, 2'b01, 32'h9, 32'h0, 32'h7, 4'h0, 1'b1);
      run(4'h4, 12'h021, 2'b01, 32'h9, 32'h0, 32'h8, 4'h0, 1'b0);
      run(4'h1, 12'h044, 2'b01, 32'h10, 32'h0, 32'h100, 4'h0, 1'b0);
      run(4'h4, 12'h321, 2'b00, 32'h8000_0000, 32'h1, 32'h0, 4'h0, 1'b1);
      run(4'h3, 12'h0DD, 2'b01, 32'h1000, 32'h0, 32'h1FC, 4'h5, 1'b1);
      run(4'h3, 12'h0DD, 2'b01, 32'h1000, 32'h0, 32'h200, 4'h5, 1'b0);
      run(4'h5, 12'h655, 2'b00, 32'h5, 32'h3, 32'h0, 4'h2, 1'b1);
      run(4'h5, 12'h655, 2'b00, 32'h5, 32'h3, 32'h0, 4'h0, 1'b1);
      run(4'h5, 12'h645, 2'b00, 32'h5, 32'h3, 32'h0, 4'h0, 1'b0);
      run(4'h6, 12'h021, 2'b00, 32'h1, 32'h0, 32'h0, 4'h0, 1'b1);
      run(4'h6, 12'h021, 2'b00, 32'h8000_0000, 32'h0, 32'h0, 4'h0, 1'b1);
      run(4'h6, 12'h033, 2'b01, 32'h0, 32'h0, 32'h0, 4'h0, 1'b1);
      run(4'h6, 12'h021, 2'b01, 32'h1, 32'h0, 32'h4, 4'h0, 1'b0);
      run(4'h0, 12'h0F0, 2'b01, 32'h100, 32'h0, 32'h3FC, 4'h0, 1'b1);
      run(4'h0, 12'h0F0, 2'b01, 32'h100, 32'h0, 32'h3FE, 4'h0, 1'b0);
      run(4'h0, 12'h0D0, 2'b01, 32'h100, 32'h0, 32'h400, 4'h0, 1'b0);
      run(4'h0, 12'h0DD, 2'b01, 32'h100, 32'h0, 32'h1FC, 4'h0, 1'b1);
      run(4'h1, 12'h760, 2'b10, 32'h2, 32'h3, 32'h0, 4'h0, 1'b1);
      // All four logic forms, carry and overflow preset to show they are kept
      for (int k = 7; k <= 10; k++) begin
         run(4'(k), 12'h433, 2'b00, 32'hF0F0_1234, 32'hFF00_1200, 32'h0, 4'h3, 1'b1);
         run(4'(k), 12'h433, 2'b00, 32'h0F0F_0000, 32'hF0F0_FFFF, 32'h0, 4'hC, 1'b1);
      end
      run(4'hA, 12'h411, 2'b00, 32'hFFFF_FFFF, 32'h0F0F_0F0F, 32'h0, 4'h0, 1'b1);
      run(4'h7, 12'h833, 2'b00, 32'h3, 32'h1, 32'h0, 4'h0, 1'b0);
      run(4'h9, 12'h432, 2'b00, 32'h3, 32'h1, 32'h0, 4'h0, 1'b0);
      // Code outside the operation set is refused
      run(4'hB, 12'h333, 2'b00, 32'h3, 32'h1, 32'h0, 4'h0, 1'b0);
      conclude();
   end

   // Hang guard: a run that outlives the ceiling is counted as a failure
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         num_errors++;
         conclude();
      end
   end

endmodule // test_add_sub_logic_alu
